// ===== hdl/scwr_pkg.sv
`default_nettype none
package scwr_pkg;

   // clock and timing
   localparam int CLK_HZ = 10_000_000;
   localparam int PULSE_MS = 250;
   localparam int OSC_START_MS = 1000;
   localparam int SETTLE_CYC = 4;
   localparam int CNT_W = 25;

   // register offsets
   localparam logic [7:0] REG_SEC0 = 8'h00;
   localparam logic [7:0] REG_SEC3 = 8'h03;
   localparam logic [7:0] REG_DC0 = 8'h04;
   localparam logic [7:0] REG_DC2 = 8'h06;
   localparam logic [7:0] REG_CTRL = 8'h07;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_CHARGER = 8'h09;

   // control field positions
   localparam int CTL_OSC_DIS = 7;
   localparam int CTL_DC_EN = 6;
   localparam int CTL_MODE = 5;
   localparam int CTL_BACKUP_SQUARE_WAVE_ENABLE = 4;
   localparam int CTL_STEER = 3;
   localparam int CTL_RS_HI = 2;
   localparam int CTL_RS_LO = 1;
   localparam int CTL_AIE = 0;

   // status field positions
   localparam int STS_OSF = 7;
   localparam int STS_AF = 0;

   // values after reset
   localparam logic [7:0] CTRL_RESET = 8'h06;
   localparam logic [7:0] CHARGER_RESET = 8'h00;

   // prescaler
   localparam int PRESC_W = 15;
   localparam logic [14:0] PRESC_SEC_WRAP = 15'h7fff;
   localparam logic [2:0] PRESC_WD_WRAP = 3'h7;

   typedef enum logic [2:0] {
      RS_IDLE,
      RS_PFAIL,
      RS_HOLD,
      RS_SETTLE,
      RS_WAIT
   } scwr_rst_state_t;

endpackage : scwr_pkg
`default_nettype wire

// ===== hdl/scwr_core.sv
// Operation
// - pointer advances per byte and wraps to 00h after passing 08h.
// - start, stop or pointer wrap copies running seconds into snapshot set.
// - 32-bit seconds up counter at 00h-03h, one count per second.
// - any write to seconds bytes restarts the 1Hz phase.
// - register access refused under power fail and until reset pin released.
// - 24-bit down counter at 04h-06h; write loads counter and seed.
// - reading seconds latches the snapshot set, reading the down counter latches its live value, into the read data register.
// - enable cleared stops down counter; all-zero write disables it too.
// - alarm mode counts seconds, sets flag at zero, reloads from seed.
// - alarm mode with irq enable holds interrupt while flag set.
// - watchdog mode counts 1/4096s; read reloads seed, write reloads new seed.
// - watchdog zero sets flag and halts counter.
// - watchdog expiry, steer 0: reset pin low 250ms, then flag cleared.
// - watchdog expiry, steer 1: irq pulse 250ms if enabled, else flag stays.
// - a running 250ms watchdog pulse cannot be cut short by software.
// - counter written during watchdog pulse waits for pulse end to count.
// - alarm logic and flag-driven interrupt work on either supply.
// - power fail drives reset low; held 250ms more after recovery.
// - oscillator disable extends power-up reset by oscillator start time.
// - falling edge on reset pin starts 250ms drive; then waits release.
// - if button still held after the first drive, on release reset pin driven low for another 250ms.
// - alarm flag takes only writes of zero.
// - oscillator stop flag set while oscillator stops, cleared by zero write.
`default_nettype none
module scwr_core #(
   parameter int PULSE_CYC = scwr_pkg::PULSE_MS * (scwr_pkg::CLK_HZ / 1000),
   parameter int OSC_START_CYC = scwr_pkg::OSC_START_MS * (scwr_pkg::CLK_HZ / 1000)
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // pins
   input wire logic oscClkIn,
   input wire logic powerFailIn,
   input wire logic rstPinIn,
   output logic rstPinOut,
   output logic rstPinOe,
   output logic intPinOut,
   output logic intPinOe,
   output logic oneHzWave,
   // byte port from serial engine
   input wire logic busStart,
   input wire logic busStop,
   input wire logic ptrLoad,
   input wire logic [7:0] ptrIn,
   input wire logic wrStrobe,
   input wire logic [7:0] wrData,
   input wire logic rdStrobe,
   output logic [7:0] rdData,
   output logic rdValid,
   output logic accessOk
);
   import scwr_pkg::*;

   localparam logic [CNT_W-1:0] PULSE_N = CNT_W'(PULSE_CYC);
   localparam logic [CNT_W-1:0] OSC_N = CNT_W'(OSC_START_CYC);
   localparam logic [CNT_W-1:0] SETTLE_N = CNT_W'(SETTLE_CYC);

   typedef struct packed {
      logic oscS1;
      logic oscS2;
      logic oscS3;
      logic pfS1;
      logic pfS2;
      logic rstS1;
      logic rstS2;
      logic rstS3;
      logic [PRESC_W-1:0] presc;
      logic [31:0] secs;
      logic [31:0] snap;
      logic [23:0] dcnt;
      logic [23:0] seed;
      logic zeroDis;
      logic halted;
      logic [7:0] ctrl;
      logic oscStopFlag;
      logic alarmFlag;
      logic [7:0] ptr;
      logic [7:0] charger;
      logic [7:0] rdData;
      logic rdValid;
      scwr_rst_state_t rsState;
      logic [CNT_W-1:0] rsCnt;
      logic rsBtn;
      logic rsWd;
      logic rsSawLow;
      logic intActive;
      logic [CNT_W-1:0] intCnt;
      logic rstDrive;
      logic intDrive;
      logic accessOk;
      logic oneHz;
   } scwr_state_t;

   localparam scwr_state_t ST_RESET = '{
      oscS1: 1'b0, oscS2: 1'b0, oscS3: 1'b0, pfS1: 1'b1, pfS2: 1'b1,
      rstS1: 1'b1, rstS2: 1'b1, rstS3: 1'b1, presc: '0, secs: '0, snap: '0,
      dcnt: '0, seed: '0, zeroDis: 1'b1, halted: 1'b0, ctrl: CTRL_RESET,
      oscStopFlag: 1'b1, alarmFlag: 1'b0, ptr: '0, charger: CHARGER_RESET,
      rdData: '0, rdValid: 1'b0, rsState: RS_PFAIL, rsCnt: '0, rsBtn: 1'b0,
      rsWd: 1'b0, rsSawLow: 1'b0, intActive: 1'b0, intCnt: '0,
      rstDrive: 1'b1, intDrive: 1'b0, accessOk: 1'b0, oneHz: 1'b0};

   scwr_state_t st_q;
   scwr_state_t st_d;

   logic oscRun;
   logic oscEdge;
   logic tickSec;
   logic tickWd;
   logic acc;
   logic wrOk;
   logic rdOk;
   logic wrap;
   logic expire;
   logic setAf;
   logic clrAf;
   logic pulseBusy;
   logic dcRun;
   logic dcTick;
   logic [23:0] seedNew;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_d = st_q;
      seedNew = st_q.seed;
      expire = 1'b0;
      setAf = 1'b0;
      clrAf = 1'b0;
      // pin synchronisers
      st_d.oscS1 = oscClkIn;
      st_d.oscS2 = st_q.oscS1;
      st_d.oscS3 = st_q.oscS2;
      st_d.pfS1 = powerFailIn;
      st_d.pfS2 = st_q.pfS1;
      st_d.rstS1 = rstPinIn;
      st_d.rstS2 = st_q.rstS1;
      st_d.rstS3 = st_q.rstS2;

      // prescaler ticks
      oscRun = !(st_q.ctrl[CTL_OSC_DIS] && st_q.pfS2);
      oscEdge = st_q.oscS2 && !st_q.oscS3 && oscRun;
      tickSec = oscEdge && (st_q.presc == PRESC_SEC_WRAP);
      tickWd = oscEdge && (st_q.presc[2:0] == PRESC_WD_WRAP);
      if (oscEdge) begin
         st_d.presc = st_q.presc + 15'h0001;
      end
      if (tickSec) begin
         st_d.secs = st_q.secs + 32'h0000_0001;
      end

      // access gate
      acc = (st_q.rsState == RS_IDLE) && !st_q.pfS2;
      wrOk = wrStrobe && acc;
      rdOk = rdStrobe && acc;
      wrap = (wrOk || rdOk) && (st_q.ptr >= REG_STATUS);

      // pointer
      if (ptrLoad) begin
         st_d.ptr = ptrIn;
      end else if (wrOk || rdOk) begin
         st_d.ptr = wrap ? REG_SEC0 : st_q.ptr + 8'h01;
      end

      // snapshot
      if (busStart || busStop || wrap) begin
         st_d.snap = st_q.secs;
      end

      // down counter
      pulseBusy = st_q.intActive || st_q.rsWd;
      dcRun = st_q.ctrl[CTL_DC_EN] && !st_q.zeroDis && !st_q.halted && !pulseBusy;
      dcTick = st_q.ctrl[CTL_MODE] ? tickWd : tickSec;
      if (dcRun && dcTick) begin
         if (st_q.dcnt <= 24'h00_0001) begin
            setAf = 1'b1;
            if (st_q.ctrl[CTL_MODE]) begin
               st_d.dcnt = '0;
               st_d.halted = 1'b1;
               expire = 1'b1;
            end else begin
               st_d.dcnt = st_q.seed;
            end
         end else begin
            st_d.dcnt = st_q.dcnt - 24'h00_0001;
         end
      end

      // register reads
      st_d.rdValid = rdStrobe;
      st_d.rdData = 8'h00;
      if (rdOk) begin
         if (st_q.ptr <= REG_SEC3) begin
            st_d.rdData = st_q.snap[8*st_q.ptr[1:0] +: 8];
         end else if (st_q.ptr <= REG_DC2) begin
            st_d.rdData = st_q.dcnt[8*(st_q.ptr[1:0]) +: 8];
            if (st_q.ctrl[CTL_MODE]) begin
               st_d.dcnt = st_q.seed;
               st_d.halted = 1'b0;
            end
         end else if (st_q.ptr == REG_CTRL) begin
            st_d.rdData = st_q.ctrl;
         end else if (st_q.ptr == REG_STATUS) begin
            st_d.rdData = {st_q.oscStopFlag, 6'h00, st_q.alarmFlag};
         end else if (st_q.ptr == REG_CHARGER) begin
            st_d.rdData = st_q.charger;
         end else begin
            st_d.rdData = 8'h00;
         end
      end

      // register writes
      if (wrOk) begin
         if (st_q.ptr <= REG_SEC3) begin
            st_d.secs[8*st_q.ptr[1:0] +: 8] = wrData;
            st_d.presc = '0;
         end else if (st_q.ptr <= REG_DC2) begin
            seedNew[8*(st_q.ptr[1:0]) +: 8] = wrData;
            st_d.seed = seedNew;
            st_d.dcnt = seedNew;
            st_d.halted = 1'b0;
            if (seedNew == 24'h00_0000) begin
               st_d.zeroDis = 1'b1;
            end
         end else if (st_q.ptr == REG_CTRL) begin
            st_d.ctrl = wrData;
            if (wrData[CTL_DC_EN] && !st_q.ctrl[CTL_DC_EN] && (st_q.seed != 24'h00_0000)) begin
               st_d.zeroDis = 1'b0;
            end
         end else if (st_q.ptr == REG_STATUS) begin
            if (!wrData[STS_AF]) begin
               clrAf = 1'b1;
            end
            if (!wrData[STS_OSF]) begin
               st_d.oscStopFlag = 1'b0;
            end
         end else if (st_q.ptr == REG_CHARGER) begin
            st_d.charger = wrData;
         end
      end
      if (!oscRun) begin
         st_d.oscStopFlag = 1'b1;
      end

      // interrupt pulse
      if (st_q.intActive) begin
         if (st_q.intCnt <= 25'h000_0001) begin
            st_d.intActive = 1'b0;
            clrAf = 1'b1;
         end else begin
            st_d.intCnt = st_q.intCnt - 25'h000_0001;
         end
      end else if (expire && st_q.ctrl[CTL_STEER] && st_q.ctrl[CTL_AIE]) begin
         st_d.intActive = 1'b1;
         st_d.intCnt = PULSE_N;
      end

      // reset sequencer
      case (st_q.rsState)
         RS_IDLE: begin
            if (st_q.pfS2) begin
               st_d.rsState = RS_PFAIL;
            end else if (expire && !st_q.ctrl[CTL_STEER]) begin
               st_d.rsState = RS_HOLD;
               st_d.rsCnt = PULSE_N;
               st_d.rsWd = 1'b1;
               st_d.rsBtn = 1'b0;
            end else if (st_q.rstS3 && !st_q.rstS2) begin
               st_d.rsState = RS_HOLD;
               st_d.rsCnt = PULSE_N;
               st_d.rsBtn = 1'b1;
            end
         end
         RS_PFAIL: begin
            st_d.rsWd = 1'b0;
            if (!st_q.pfS2) begin
               st_d.rsState = RS_HOLD;
               st_d.rsBtn = 1'b0;
               st_d.rsCnt = st_q.ctrl[CTL_OSC_DIS] ? PULSE_N + OSC_N : PULSE_N;
            end
         end
         RS_HOLD: begin
            if (st_q.pfS2) begin
               st_d.rsState = RS_PFAIL;
            end else if (st_q.rsCnt <= 25'h000_0001) begin
               st_d.rsState = RS_SETTLE;
               st_d.rsCnt = SETTLE_N;
               st_d.rsWd = 1'b0;
               if (st_q.rsWd) begin
                  clrAf = 1'b1;
               end
            end else begin
               st_d.rsCnt = st_q.rsCnt - 25'h000_0001;
            end
         end
         RS_SETTLE: begin
            if (st_q.pfS2) begin
               st_d.rsState = RS_PFAIL;
            end else if (st_q.rsCnt <= 25'h000_0001) begin
               st_d.rsState = st_q.rsBtn ? RS_WAIT : RS_IDLE;
               st_d.rsSawLow = 1'b0;
            end else begin
               st_d.rsCnt = st_q.rsCnt - 25'h000_0001;
            end
         end
         RS_WAIT: begin
            if (st_q.pfS2) begin
               st_d.rsState = RS_PFAIL;
            end else if (!st_q.rstS2) begin
               st_d.rsSawLow = 1'b1;
            end else if (st_q.rsSawLow) begin
               st_d.rsState = RS_HOLD;
               st_d.rsCnt = PULSE_N;
               st_d.rsBtn = 1'b0;
            end else begin
               st_d.rsState = RS_IDLE;
            end
         end
         default: begin
            st_d.rsState = RS_PFAIL;
         end
      endcase

      // alarm flag, set wins
      st_d.alarmFlag = setAf || (st_q.alarmFlag && !clrAf);

      // registered pin drives
      st_d.rstDrive = (st_d.rsState == RS_PFAIL) || (st_d.rsState == RS_HOLD);
      st_d.intDrive = st_d.intActive ||
         (!st_d.ctrl[CTL_MODE] && st_d.ctrl[CTL_AIE] && st_d.alarmFlag);
      st_d.accessOk = (st_d.rsState == RS_IDLE) && !st_q.pfS2;
      st_d.oneHz = st_d.presc[PRESC_W-1];
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= ST_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign rstPinOut = 1'b0;
   assign intPinOut = 1'b0;
   assign rstPinOe = st_q.rstDrive;
   assign intPinOe = st_q.intDrive;
   assign oneHzWave = st_q.oneHz;
   assign rdData = st_q.rdData;
   assign rdValid = st_q.rdValid;
   assign accessOk = st_q.accessOk;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   ptr_wrap_a: assert property ((wrStrobe && acc && !ptrLoad && st_q.ptr == REG_STATUS) |=> st_q.ptr == REG_SEC0)
      else $error("pointer did not wrap");
   snap_copy_a: assert property (busStart |=> st_q.snap == $past(st_q.secs))
      else $error("snapshot not taken on start");
   sec_count_a: assert property ((tickSec && !wrStrobe) |=> st_q.secs == $past(st_q.secs) + 32'h0000_0001)
      else $error("seconds did not advance");
   phase_restart_a: assert property ((wrStrobe && acc && !ptrLoad && st_q.ptr <= REG_SEC3) |=> st_q.presc == '0)
      else $error("prescaler not restarted");
   pf_refuse_a: assert property (st_q.pfS2 |=> !accessOk ##1 !accessOk)
      else $error("access granted under power fail");
   seed_load_a: assert property ((wrStrobe && acc && !ptrLoad && st_q.ptr == REG_DC0)
      |=> st_q.seed[7:0] == $past(wrData) && st_q.dcnt == st_q.seed)
      else $error("seed and counter not loaded");
   dc_stop_a: assert property ((!st_q.ctrl[CTL_DC_EN] && !wrStrobe && !rdStrobe) |=> $stable(st_q.dcnt))
      else $error("disabled counter moved");
   alarm_int_a: assert property ((!st_q.ctrl[CTL_MODE] && st_q.ctrl[CTL_AIE] && st_q.alarmFlag
      && !wrStrobe && !clrAf) |=> intPinOe)
      else $error("interrupt not held by alarm flag");
   wd_halt_a: assert property ((expire) |=> st_q.halted && st_q.alarmFlag && st_q.dcnt == '0)
      else $error("watchdog did not halt");
   pf_drive_a: assert property (st_q.pfS2 |=> ##1 rstPinOe)
      else $error("reset not driven on power fail");
   af_one_a: assert property ((!st_q.alarmFlag && !setAf) |=> !st_q.alarmFlag)
      else $error("alarm flag set without event");

endmodule : scwr_core
`default_nettype wire

// ===== bench/scwr_host.sv
`default_nettype none
module scwr_host (
   // clock
   input wire logic clk,
   // byte port toward the core
   output logic busStart,
   output logic busStop,
   output logic ptrLoad,
   output logic [7:0] ptrIn,
   output logic wrStrobe,
   output logic [7:0] wrData,
   output logic rdStrobe
);
   timeunit 1ns;
   timeprecision 1ns;

   // expected read bytes, oldest first
   logic [7:0] expQ[$];

   initial begin
      busStart = 1'b0;
      busStop = 1'b0;
      ptrLoad = 1'b0;
      ptrIn = 8'h00;
      wrStrobe = 1'b0;
      wrData = 8'h00;
      rdStrobe = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // released data lines show the inverse of the last value
   task automatic setPtr(input logic [7:0] a);
      @(posedge clk);
      ptrLoad <= 1'b1;
      ptrIn <= a;
      @(posedge clk);
      ptrLoad <= 1'b0;
      ptrIn <= ~a;
   endtask : setPtr

   task automatic wr(input logic [7:0] d);
      @(posedge clk);
      wrStrobe <= 1'b1;
      wrData <= d;
      @(posedge clk);
      wrStrobe <= 1'b0;
      wrData <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] e);
      expQ.push_back(e);
      @(posedge clk);
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
   endtask : rd

   // start when stop is 0, stop otherwise
   task automatic mark(input logic stop);
      @(posedge clk);
      busStart <= !stop;
      busStop <= stop;
      @(posedge clk);
      busStart <= 1'b0;
      busStop <= 1'b0;
   endtask : mark
endmodule : scwr_host
`default_nettype wire

// ===== bench/test_seconds_counter_watchdog_reset.sv
`default_nettype none
module test_seconds_counter_watchdog_reset;
   timeunit 1ns;
   timeprecision 1ns;
   import scwr_pkg::*;

   localparam int PULSE = 20;
   localparam int OSC = 10;

   logic clk, reset_n, oscClk, powerFailIn, btnLow;
   logic rstPinOut, rstPinOe, intPinOut, intPinOe, oneHzWave;
   logic busStart, busStop, ptrLoad, wrStrobe, rdStrobe, rdValid, accessOk;
   logic [7:0] ptrIn, wrData, rdData;
   logic [2:0] obs;
   logic [31:0] rngState = 32'h0000_005a;
   wire logic rstPinIn;
   int nMismatch = 0;
   int checked = 0;

   // reset wire with pull-up, low while anyone pulls
   assign rstPinIn = !(rstPinOe || btnLow);
   assign obs = {intPinOe, rstPinOe, accessOk};

   scwr_core #(.PULSE_CYC(PULSE), .OSC_START_CYC(OSC)) i_dut (
      .clk(clk), .reset_n(reset_n), .oscClkIn(oscClk), .powerFailIn(powerFailIn),
      .rstPinIn(rstPinIn), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
      .intPinOut(intPinOut), .intPinOe(intPinOe), .oneHzWave(oneHzWave),
      .busStart(busStart), .busStop(busStop), .ptrLoad(ptrLoad), .ptrIn(ptrIn),
      .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe), .rdData(rdData),
      .rdValid(rdValid), .accessOk(accessOk));

   scwr_host i_host (
      .clk(clk), .busStart(busStart), .busStop(busStop), .ptrLoad(ptrLoad),
      .ptrIn(ptrIn), .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      oscClk = 1'b0;
      forever #170 oscClk = ~oscClk;
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rnd();
      rngState ^= rngState << 13;
      rngState ^= rngState >> 17;
      rngState ^= rngState << 5;
      return rngState[7:0];
   endfunction : rnd

   task automatic finish_test();
      $display("mismatches %0d, checks %0d", nMismatch, checked);
      if (nMismatch == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         nMismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic waitFor(input int k, input logic v, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge clk);
         if (obs[k] === v)
            break;
      end
      if (i == lim) begin
         nMismatch++;
         $display("mismatch at %0t: wait on output %0d ran out", $time, k);
         finish_test();
      end
   endtask : waitFor

   task automatic pulseLen(input int k, output int n);
      n = 0;
      while (obs[k] === 1'b1 && n < 5000) begin
         n++;
         @(posedge clk);
      end
      if (n == 5000) begin
         nMismatch++;
         $display("mismatch at %0t: pulse on output %0d did not end", $time, k);
         finish_test();
      end
   endtask : pulseLen

   // read results against the oldest note
   always @(posedge clk) begin
      if (rdValid === 1'b1) begin
         if (i_host.expQ.size() == 0) begin
            nMismatch++;
            $display("mismatch at %0t: read result without request", $time);
         end else
            cmp(rdData, i_host.expQ.pop_front());
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] b[7];
      int n;
      int i;
      reset_n = 1'b0;
      powerFailIn = 1'b0;
      btnLow = 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      waitFor(0, 1'b1, 200);
      // reset values; reading status wraps to the first place
      i_host.setPtr(REG_CHARGER);
      i_host.rd(CHARGER_RESET);
      i_host.setPtr(REG_CTRL);
      i_host.rd(CTRL_RESET);
      i_host.rd(8'h80);
      i_host.rd(8'h00);
      i_host.setPtr(REG_STATUS);
      i_host.wr(8'h01);
      i_host.setPtr(REG_STATUS);
      i_host.rd(8'h00);
      // seconds and idle down counter as storage
      i_host.setPtr(REG_SEC0);
      i_host.mark(1'b0);
      for (i = 0; i < 7; i++) begin
         b[i] = rnd();
         i_host.wr(b[i]);
      end
      i_host.mark(1'b1);
      i_host.setPtr(REG_SEC0);
      for (i = 0; i < 7; i++)
         i_host.rd(b[i]);
      i_host.rd(CTRL_RESET);
      i_host.rd(8'h00);
      i_host.rd(b[0]);
      // watchdog on the reset pin
      i_host.setPtr(REG_DC0);
      i_host.wr(8'h03);
      i_host.wr(8'h00);
      i_host.wr(8'h00);
      i_host.setPtr(REG_CTRL);
      i_host.wr(8'h60);
      waitFor(1, 1'b1, 500);
      pulseLen(1, n);
      cmp(n, PULSE);
      waitFor(0, 1'b1, 20);
      i_host.setPtr(REG_STATUS);
      i_host.rd(8'h00);
      // watchdog on the interrupt pin, software cannot cut it short
      i_host.setPtr(REG_CTRL);
      i_host.wr(8'h69);
      i_host.setPtr(REG_DC0);
      i_host.wr(8'h03);
      waitFor(2, 1'b1, 500);
      fork
         pulseLen(2, n);
         begin
            i_host.setPtr(REG_STATUS);
            i_host.wr(8'h00);
            i_host.setPtr(REG_CTRL);
            i_host.wr(8'h68);
            i_host.setPtr(REG_DC0);
            i_host.wr(8'h04);
         end
      join
      cmp(n, PULSE);
      // expiry with interrupt disabled leaves the flag up
      repeat (300) @(posedge clk);
      i_host.setPtr(REG_STATUS);
      i_host.rd(8'h01);
      cmp(obs[2], 1'b0);
      i_host.setPtr(REG_CTRL);
      i_host.wr(8'h41);
      waitFor(2, 1'b1, 5);
      i_host.setPtr(REG_STATUS);
      i_host.wr(8'h00);
      waitFor(2, 1'b0, 5);
      // pushbutton held past the first hold
      btnLow <= 1'b1;
      waitFor(1, 1'b1, 10);
      pulseLen(1, n);
      cmp(n, PULSE);
      repeat (10) begin
         @(posedge clk);
         cmp(obs[1:0], 2'b00);
      end
      btnLow <= 1'b0;
      waitFor(1, 1'b1, 10);
      pulseLen(1, n);
      cmp(n, PULSE);
      waitFor(0, 1'b1, 20);
      // power fail with oscillator disabled
      i_host.setPtr(REG_CTRL);
      i_host.wr(8'h80);
      powerFailIn <= 1'b1;
      waitFor(1, 1'b1, 10);
      waitFor(0, 1'b0, 10);
      i_host.rd(8'h00);
      powerFailIn <= 1'b0;
      pulseLen(1, n);
      cmp(n >= PULSE + OSC && n <= PULSE + OSC + 5, 1'b1);
      waitFor(0, 1'b1, 20);
      i_host.setPtr(REG_STATUS);
      i_host.rd(8'h80);
      // seconds write restarts the square wave, first rise half a second later
      cmp({rstPinOut, intPinOut}, 2'b00);
      i_host.setPtr(REG_SEC0);
      i_host.wr(b[0]);
      n = 0;
      while (oneHzWave !== 1'b1 && n < 60000) begin
         @(posedge clk);
         n++;
      end
      cmp(n >= 55700 && n <= 55716, 1'b1);
      repeat (3) @(posedge clk);
      cmp(i_host.expQ.size(), 0);
      finish_test();
   end
endmodule : test_seconds_counter_watchdog_reset
`default_nettype wire
